// ===== logic/memory_map_address_decoder.sv
// memory map address decoder with zero-page and high-page registers
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
module memory_map_address_decoder #(
    parameter bit LARGE_FLASH = 1'b1,
    parameter logic [7:0] IAR_EN_RESET = 8'h01
) (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // register bus
    input wire memmap_pkg::bus_req_s req,
    output logic [7:0] rdata,
    // memory selects and illegal-address reset
    output memmap_pkg::mem_sel_s mem_sel,
    output logic illegal_reset,
    // register contents toward the modules that own them
    output logic [7:0] port_dir_a,
    output logic [7:0] port_dir_d,
    output logic [7:0] flash_ctrl,
    output logic [15:0] break_addr,
    // status from neighbouring modules
    input wire logic [7:0] break_status_in,
    input wire logic [7:0] reset_cause_in,
    input wire logic [7:0] supply_status_in,
    input wire logic [7:0] irq_status_in
);

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    function automatic logic in_range(logic [15:0] a, logic [15:0] b,
                                      logic [15:0] s);
        logic [16:0] lo;
        logic [16:0] hi;
        lo = {1'b0, b};
        hi = lo + {1'b0, s};
        return ({1'b0, a} >= lo) && ({1'b0, a} < hi);
    endfunction

    function automatic logic [7:0] masked(logic [7:0] v, logic [7:0] m);
        return v & m;
    endfunction

    memmap_pkg::region_e region;
    logic hreg_hit;
    logic zp_hit;
    logic implemented;

    always_comb begin
        hreg_hit = 1'b0;
        case (req.addr)
            memmap_pkg::A_BRK_STAT, memmap_pkg::A_RST_CAUSE,
            memmap_pkg::A_BRK_FLAG, memmap_pkg::A_FL_TEST,
            memmap_pkg::A_FL_CTRL, memmap_pkg::A_BRK_HIGH,
            memmap_pkg::A_BRK_LOW, memmap_pkg::A_BRK_SC,
            memmap_pkg::A_SUPPLY, memmap_pkg::A_FL_PROT,
            memmap_pkg::A_IAR_CTRL: hreg_hit = 1'b1; // RULE11
            default: hreg_hit = 1'b0;
        endcase
    end

    // zero page: only the listed slots are implemented here
    assign zp_hit = (req.addr <= memmap_pkg::ZPAGE_LAST) && // RULE10
                    (req.addr <= memmap_pkg::A_PORT_E);

    always_comb begin
        region = memmap_pkg::RG_NONE;
        if (req.addr <= memmap_pkg::ZPAGE_LAST) begin
            region = zp_hit ? memmap_pkg::RG_ZPAGE : memmap_pkg::RG_NONE;
        end else if (hreg_hit) begin
            region = memmap_pkg::RG_HREG;
        end else if (in_range(req.addr, memmap_pkg::RAM_BASE,
                              memmap_pkg::RAM_SIZE)) begin
            region = memmap_pkg::RG_RAM; // RULE4
        end else if (in_range(req.addr, memmap_pkg::VEC_BASE,
                              memmap_pkg::VEC_SIZE)) begin
            region = memmap_pkg::RG_VEC; // RULE5
        end else if (in_range(req.addr, memmap_pkg::MON_BASE,
                              memmap_pkg::MON_SIZE)) begin
            region = memmap_pkg::RG_MON; // RULE6
        end else if (in_range(req.addr, memmap_pkg::BURN_BASE,
                              memmap_pkg::BURN_SIZE)) begin
            region = memmap_pkg::RG_BURN; // RULE7
        end else if (LARGE_FLASH && in_range(req.addr,
                     memmap_pkg::FLASH8_BASE, memmap_pkg::FLASH8_USER)) begin
            region = memmap_pkg::RG_FLASH; // RULE2
        end else if (!LARGE_FLASH && in_range(req.addr,
                     memmap_pkg::FLASH4_BASE, memmap_pkg::FLASH4_USER)) begin
            region = memmap_pkg::RG_FLASH; // RULE3
        end else begin
            region = memmap_pkg::RG_NONE;
        end
    end

    // full 16-bit address; values that fall in no region decode to RG_NONE
    assign implemented = (region != memmap_pkg::RG_NONE); // RULE1

    // ----------------------------------------------------------------
    // memory selects, registered
    // ----------------------------------------------------------------
    logic acc;
    assign acc = req.rd | req.wr;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mem_sel <= '0;
        end else begin
            mem_sel.sel_ram <= acc && (region == memmap_pkg::RG_RAM);
            mem_sel.sel_flash <= acc && (region == memmap_pkg::RG_FLASH);
            mem_sel.sel_vec <= acc && (region == memmap_pkg::RG_VEC);
            // read-only regions select on reads only
            mem_sel.sel_mon <= req.rd && (region == memmap_pkg::RG_MON);
            mem_sel.sel_burn <= req.rd && (region == memmap_pkg::RG_BURN);
        end
    end

    // ----------------------------------------------------------------
    // illegal-address reset control
    // ----------------------------------------------------------------
    logic iar_en_r;
    logic iar_flag_r;
    logic illegal_hit;
    assign illegal_hit = acc && !implemented;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            iar_en_r <= IAR_EN_RESET[0];
        end else if (req.wr && req.addr == memmap_pkg::A_IAR_CTRL) begin
            iar_en_r <= |(req.wdata & memmap_pkg::IAR_EN_BIT);
        end
    end

    // sticky cause flag; set wins over a clearing write
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            iar_flag_r <= 1'b0;
        end else if (illegal_hit && iar_en_r) begin
            iar_flag_r <= 1'b1;
        end else if (req.wr && req.addr == memmap_pkg::A_IAR_CTRL &&
                     |(req.wdata & memmap_pkg::IAR_FLAG_BIT)) begin
            iar_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            illegal_reset <= 1'b0;
        end else begin
            illegal_reset <= illegal_hit && iar_en_r; // RULE8
        end
    end

    // ----------------------------------------------------------------
    // port data: kept through reset, so no reset term
    // ----------------------------------------------------------------
    logic [7:0] pa_r, pb_r, pc_r, pd_r, pe_r;

    always_ff @(posedge mclk) begin
        if (req.wr) begin
            case (req.addr)
                memmap_pkg::A_PORT_A:
                    pa_r <= masked(req.wdata, memmap_pkg::M_PORT_A); // RULE20
                memmap_pkg::A_PORT_B:
                    pb_r <= masked(req.wdata, memmap_pkg::M_PORT_B); // RULE19
                memmap_pkg::A_PORT_C:
                    pc_r <= masked(req.wdata, memmap_pkg::M_PORT_C);
                memmap_pkg::A_PORT_D:
                    pd_r <= masked(req.wdata, memmap_pkg::M_PORT_D);
                memmap_pkg::A_PORT_E:
                    pe_r <= masked(req.wdata, memmap_pkg::M_PORT_E);
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // direction registers, cleared on reset
    // ----------------------------------------------------------------
    logic [7:0] da_r, db_r, dc_r, dd_r;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            da_r <= memmap_pkg::ZERO8; // RULE20
            db_r <= memmap_pkg::ZERO8;
            dc_r <= memmap_pkg::ZERO8;
            dd_r <= memmap_pkg::ZERO8;
        end else if (req.wr) begin
            case (req.addr)
                memmap_pkg::A_DIR_A:
                    da_r <= masked(req.wdata, memmap_pkg::M_PORT_A); // RULE19
                memmap_pkg::A_DIR_B:
                    db_r <= masked(req.wdata, memmap_pkg::M_PORT_B);
                memmap_pkg::A_DIR_C:
                    dc_r <= masked(req.wdata, memmap_pkg::M_PORT_C);
                memmap_pkg::A_DIR_D:
                    dd_r <= masked(req.wdata, memmap_pkg::M_PORT_D);
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // high-page writable registers
    // ----------------------------------------------------------------
    logic [7:0] brk_flag_r, fl_ctrl_r, brk_hi_r, brk_lo_r, brk_sc_r;
    logic [7:0] fl_prot_r;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            brk_flag_r <= memmap_pkg::ZERO8;
            fl_ctrl_r <= memmap_pkg::ZERO8;
            brk_hi_r <= memmap_pkg::ZERO8;
            brk_lo_r <= memmap_pkg::ZERO8;
            brk_sc_r <= memmap_pkg::ZERO8;
            fl_prot_r <= memmap_pkg::ZERO8;
        end else if (req.wr) begin
            case (req.addr)
                memmap_pkg::A_BRK_FLAG: brk_flag_r <= req.wdata; // RULE13
                memmap_pkg::A_FL_CTRL: fl_ctrl_r <= req.wdata; // RULE14
                // overlap: writes always go to the break registers
                memmap_pkg::A_BRK_HIGH: brk_hi_r <= req.wdata; // RULE15
                memmap_pkg::A_BRK_LOW: brk_lo_r <= req.wdata; // RULE18
                memmap_pkg::A_BRK_SC: brk_sc_r <= req.wdata;
                memmap_pkg::A_FL_PROT: fl_prot_r <= req.wdata; // RULE17
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            port_dir_a <= memmap_pkg::ZERO8;
            port_dir_d <= memmap_pkg::ZERO8;
            flash_ctrl <= memmap_pkg::ZERO8;
            break_addr <= '0;
        end else begin
            port_dir_a <= da_r;
            port_dir_d <= dd_r;
            flash_ctrl <= fl_ctrl_r;
            break_addr <= {brk_hi_r, brk_lo_r};
        end
    end

    // ----------------------------------------------------------------
    // read mux; reads at 0xFE09..0xFE0B return interrupt status when
    // the break status-control enable bit is clear (overlap resolution)
    // ----------------------------------------------------------------
    logic [7:0] rd_nxt;
    logic irq_view;
    assign irq_view = ~brk_sc_r[7];

    always_comb begin
        rd_nxt = memmap_pkg::ZERO8;
        case (req.addr)
            memmap_pkg::A_PORT_A: rd_nxt = masked(pa_r, memmap_pkg::M_PORT_A);
            memmap_pkg::A_PORT_B: rd_nxt = masked(pb_r, memmap_pkg::M_PORT_B);
            memmap_pkg::A_PORT_C: rd_nxt = masked(pc_r, memmap_pkg::M_PORT_C);
            memmap_pkg::A_PORT_D: rd_nxt = masked(pd_r, memmap_pkg::M_PORT_D);
            memmap_pkg::A_PORT_E: rd_nxt = masked(pe_r, memmap_pkg::M_PORT_E);
            memmap_pkg::A_DIR_A: rd_nxt = da_r;
            memmap_pkg::A_DIR_B: rd_nxt = db_r;
            memmap_pkg::A_DIR_C: rd_nxt = dc_r;
            memmap_pkg::A_DIR_D: rd_nxt = dd_r;
            memmap_pkg::A_BRK_STAT: rd_nxt = break_status_in; // RULE11
            memmap_pkg::A_RST_CAUSE: rd_nxt = reset_cause_in; // RULE12
            memmap_pkg::A_BRK_FLAG: rd_nxt = brk_flag_r;
            memmap_pkg::A_FL_TEST: rd_nxt = memmap_pkg::ZERO8; // RULE14
            memmap_pkg::A_FL_CTRL: rd_nxt = fl_ctrl_r;
            memmap_pkg::A_BRK_HIGH:
                rd_nxt = irq_view ? irq_status_in : brk_hi_r; // RULE18
            memmap_pkg::A_BRK_LOW:
                rd_nxt = irq_view ? irq_status_in : brk_lo_r;
            memmap_pkg::A_BRK_SC:
                rd_nxt = irq_view ? irq_status_in : brk_sc_r;
            memmap_pkg::A_SUPPLY: rd_nxt = supply_status_in; // RULE16
            memmap_pkg::A_FL_PROT: rd_nxt = fl_prot_r;
            memmap_pkg::A_IAR_CTRL:
                rd_nxt = {iar_flag_r, 6'h00, iar_en_r};
            default: rd_nxt = memmap_pkg::ZERO8;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= memmap_pkg::ZERO8;
        end else begin
            rdata <= req.rd ? rd_nxt : memmap_pkg::ZERO8;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_iar_fires;
        @(posedge mclk) disable iff (!arst_n)
        (acc && !implemented && iar_en_r) |=> illegal_reset;
    endproperty
    a_iar_fires: assert property (p_iar_fires) // RULE8
        else $error("illegal access did not raise reset");

    property p_iar_quiet;
        @(posedge mclk) disable iff (!arst_n)
        !iar_en_r |=> !illegal_reset;
    endproperty
    a_iar_quiet: assert property (p_iar_quiet) // RULE8
        else $error("reset raised while disabled");

    property p_ram_sel;
        @(posedge mclk) disable iff (!arst_n)
        (req.rd && req.addr == memmap_pkg::RAM_BASE) |=> mem_sel.sel_ram;
    endproperty
    a_ram_sel: assert property (p_ram_sel) // RULE4
        else $error("ram base not selected");

    property p_mon_ro;
        @(posedge mclk) disable iff (!arst_n)
        (req.wr && !req.rd) |=> !mem_sel.sel_mon && !mem_sel.sel_burn;
    endproperty
    a_mon_ro: assert property (p_mon_ro) // RULE6
        else $error("rom selected on write");

    property p_port_mask;
        @(posedge mclk) disable iff (!arst_n)
        (req.rd && req.addr == memmap_pkg::A_PORT_A) |=> rdata[7:4] == 4'h0;
    endproperty
    a_port_mask: assert property (p_port_mask) // RULE19
        else $error("unimplemented port bits read nonzero");

    property p_dir_rt;
        @(posedge mclk) disable iff (!arst_n)
        (req.wr && req.addr == memmap_pkg::A_DIR_D) ##1
        (req.rd && req.addr == memmap_pkg::A_DIR_D && !req.wr)
        |=> rdata == ($past(req.wdata, 2) & memmap_pkg::M_PORT_D);
    endproperty
    a_dir_rt: assert property (p_dir_rt) // RULE19
        else $error("direction readback mismatch");

    property p_fe01;
        @(posedge mclk) disable iff (!arst_n)
        (req.rd && req.addr == memmap_pkg::A_RST_CAUSE) |=>
        rdata == $past(reset_cause_in);
    endproperty
    a_fe01: assert property (p_fe01) // RULE12
        else $error("reset cause read wrong");

    property p_supply;
        @(posedge mclk) disable iff (!arst_n)
        (req.rd && req.addr == memmap_pkg::A_SUPPLY) |=>
        rdata == $past(supply_status_in);
    endproperty
    a_supply: assert property (p_supply) // RULE16
        else $error("supply status read wrong");

    property p_brk_addr;
        @(posedge mclk) disable iff (!arst_n)
        (req.wr && req.addr == memmap_pkg::A_BRK_HIGH) |-> ##2
        break_addr[15:8] == $past(req.wdata, 2);
    endproperty
    a_brk_addr: assert property (p_brk_addr) // RULE15
        else $error("break address high not loaded");

    property p_burn_sel;
        @(posedge mclk) disable iff (!arst_n)
        (req.rd && req.addr == memmap_pkg::BURN_BASE) |=> mem_sel.sel_burn;
    endproperty
    a_burn_sel: assert property (p_burn_sel) // RULE7
        else $error("burn-in base not selected");

    property p_vec_sel;
        @(posedge mclk) disable iff (!arst_n)
        (req.rd && req.addr == memmap_pkg::VEC_BASE) |=> mem_sel.sel_vec;
    endproperty
    a_vec_sel: assert property (p_vec_sel) // RULE5
        else $error("vector base not selected");

    property p_flag_set;
        @(posedge mclk) disable iff (!arst_n)
        (acc && !implemented && iar_en_r) |=> iar_flag_r;
    endproperty
    a_flag_set: assert property (p_flag_set) // RULE8
        else $error("illegal access did not set the cause flag");
endmodule

// ===== inc/memmap_pkg.sv
// constants and types for the memory map address decoder
// Function
// RULE1: decode a 16-bit address over a 64K-byte space
// RULE2: large variant maps 8K flash, 7680 bytes user space
// RULE3: small variant maps 4K flash, 4096 bytes user space
// RULE4: map a 384-byte read-write RAM region
// RULE5: reserve a 36-byte user vector region
// RULE6: map a 310-byte read-only monitor region
// RULE7: map a separate 544-byte read-only burn-in region
// RULE8: unimplemented access raises reset only when that reset is enabled
// RULE9: accessing party avoids reserved locations; results undefined
// RULE10: most registers decode in zero page 0x0000 to 0x003F
// RULE11: break status register decodes at 0xFE00
// RULE12: reset cause status register decodes at 0xFE01
// RULE13: break flag control register decodes at 0xFE03
// RULE14: flash control at 0xFE08, reserved flash test control at 0xFE07
// RULE15: break address high/low at 0xFE09/0xFE0A, status control 0xFE0B
// RULE16: supply monitor status register decodes at 0xFE0C
// RULE17: flash block protect register decodes at 0xFF7E
// RULE18: interrupt status overlaps break registers; overlap must be resolved
// RULE19: unimplemented port bits read zero, writes ignored
// RULE20: direction registers clear on reset; port data keeps contents
package memmap_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    // region bases and sizes
    localparam logic [16:0] SPACE_SIZE = 17'h10000;
    localparam logic [15:0] ZPAGE_LAST = 16'h003F;
    localparam logic [15:0] RAM_BASE = 16'h0040;
    localparam logic [15:0] RAM_SIZE = 16'h0180;
    localparam logic [15:0] FLASH8_BASE = 16'hE000;
    localparam logic [15:0] FLASH8_USER = 16'h1E00;
    localparam logic [15:0] FLASH4_BASE = 16'hEE00;
    localparam logic [15:0] FLASH4_USER = 16'h1000;
    localparam logic [15:0] MON_BASE = 16'hFE20;
    localparam logic [15:0] MON_SIZE = 16'h0136;
    // burn-in sits just below the large flash so no two regions overlap
    localparam logic [15:0] BURN_BASE = 16'hDDE0;
    localparam logic [15:0] BURN_SIZE = 16'h0220;
    localparam logic [15:0] VEC_BASE = 16'hFFDC;
    localparam logic [15:0] VEC_SIZE = 16'h0024;
    // register addresses
    localparam logic [15:0] A_PORT_A = 16'h0000;
    localparam logic [15:0] A_PORT_B = 16'h0001;
    localparam logic [15:0] A_PORT_C = 16'h0002;
    localparam logic [15:0] A_PORT_D = 16'h0003;
    localparam logic [15:0] A_DIR_A = 16'h0004;
    localparam logic [15:0] A_DIR_B = 16'h0005;
    localparam logic [15:0] A_DIR_C = 16'h0006;
    localparam logic [15:0] A_DIR_D = 16'h0007;
    localparam logic [15:0] A_PORT_E = 16'h0008;
    localparam logic [15:0] A_BRK_STAT = 16'hFE00;
    localparam logic [15:0] A_RST_CAUSE = 16'hFE01;
    localparam logic [15:0] A_BRK_FLAG = 16'hFE03;
    localparam logic [15:0] A_FL_TEST = 16'hFE07;
    localparam logic [15:0] A_FL_CTRL = 16'hFE08;
    localparam logic [15:0] A_BRK_HIGH = 16'hFE09;
    localparam logic [15:0] A_BRK_LOW = 16'hFE0A;
    localparam logic [15:0] A_BRK_SC = 16'hFE0B;
    localparam logic [15:0] A_SUPPLY = 16'hFE0C;
    localparam logic [15:0] A_FL_PROT = 16'hFF7E;
    localparam logic [15:0] A_IAR_CTRL = 16'hFE0F;
    // implemented-bit masks
    localparam logic [7:0] M_PORT_A = 8'h0F;
    localparam logic [7:0] M_PORT_B = 8'h3F;
    localparam logic [7:0] M_PORT_C = 8'h03;
    localparam logic [7:0] M_PORT_D = 8'h7F;
    localparam logic [7:0] M_PORT_E = 8'h03;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [7:0] IAR_EN_BIT = 8'h01;
    localparam logic [7:0] IAR_FLAG_BIT = 8'h80;
    localparam logic [7:0] IAR_MASK = 8'h81;

    typedef enum {
        RG_NONE, RG_ZPAGE, RG_RAM, RG_FLASH, RG_VEC, RG_MON, RG_BURN, RG_HREG
    } region_e;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } bus_req_s;

    typedef struct packed {
        logic sel_ram;
        logic sel_flash;
        logic sel_vec;
        logic sel_mon;
        logic sel_burn;
    } mem_sel_s;
endpackage

// ===== verification/cpu_bus_model.sv
// processor-side bus master model driving the decoder's register port
`timescale 1ns/10ps
module cpu_bus_model (
    // clock
    input wire logic mclk,
    // request toward the decoder
    output memmap_pkg::bus_req_s req
);
    initial begin
        req = '0;
    end

    // --------------------------------------------------------------
    // bus cycles
    // --------------------------------------------------------------
    // one request per edge; the slave never stalls, so the next call
    // replaces it at the edge that takes it
    task automatic put(logic rd, logic [15:0] a, logic [7:0] d);
        @(posedge mclk);
        req <= {rd, ~rd, a, d};
    endtask

    // released lines show the inverse, never a stale copy
    task automatic idle();
        @(posedge mclk);
        req <= {1'b0, 1'b0, ~req.addr, ~req.wdata};
    endtask
endmodule

// ===== verification/test_memory_map_address_decoder.sv
// self-checking bench for the memory map address decoder
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((e) !== (g)) begin \
    failures++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module test_memory_map_address_decoder;
    typedef struct packed {
        logic chk;
        logic [7:0] dat;
        memmap_pkg::mem_sel_s sel;
        logic ill;
    } note_s;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    memmap_pkg::bus_req_s req;
    memmap_pkg::mem_sel_s mem_sel;
    logic [7:0] rdata, port_dir_a, port_dir_d, flash_ctrl;
    logic [15:0] break_addr;
    logic illegal_reset, taken;
    logic [7:0] brk_in = 8'h00, rst_in = 8'h00, sup_in = 8'h00, irq_in = 8'h00;
    logic en_m = 1'b1, flag_m = 1'b0;
    note_s notes[$];
    note_s cur;
    int failures = 0, cmp_count = 0, cycles = 0, i;
    logic [7:0] mem_m [0:8];
    logic [7:0] d, h, l, c;
    logic [7:0] mask_t [0:8] = '{8'h0F, 8'h3F, 8'h03, 8'h7F, 8'h0F, 8'h3F,
        8'h03, 8'h7F, 8'h03};
    // first and last bytes of the RAM, burn-in, monitor and vector regions, the first flash byte, and the gaps around them
    logic [15:0] edge_addr [0:16] = '{16'h0009, 16'h003F, 16'h0040, 16'h01BF,
        16'h01C0, 16'hDDDF, 16'hDDE0, 16'hDFFF, 16'hE000, 16'hFBFF, 16'hFE02,
        16'hFE20, 16'hFF55, 16'hFF56, 16'hFFDB, 16'hFFDC, 16'hFFFF};

    always #50 mclk = ~mclk;

    memory_map_address_decoder memory_map_address_decoder_i (.mclk(mclk),
        .arst_n(arst_n), .req(req), .rdata(rdata), .mem_sel(mem_sel),
        .illegal_reset(illegal_reset), .port_dir_a(port_dir_a),
        .port_dir_d(port_dir_d), .flash_ctrl(flash_ctrl),
        .break_addr(break_addr), .break_status_in(brk_in),
        .reset_cause_in(rst_in), .supply_status_in(sup_in),
        .irq_status_in(irq_in));
    cpu_bus_model cpu_bus_model_i (.mclk(mclk), .req(req));

    // --------------------------------------------------------------
    // expectation model
    // --------------------------------------------------------------
    function automatic bit in_r(int a, logic [15:0] b, logic [15:0] s);
        return a >= int'(b) && a < int'(b) + int'(s);
    endfunction

    function automatic note_s expect_acc(logic rd, logic [15:0] a);
        note_s n;
        bit impl;
        n = '0;
        n.sel.sel_ram = in_r(a, memmap_pkg::RAM_BASE, memmap_pkg::RAM_SIZE);
        n.sel.sel_flash = in_r(a, memmap_pkg::FLASH8_BASE,
            memmap_pkg::FLASH8_USER);
        n.sel.sel_vec = in_r(a, memmap_pkg::VEC_BASE, memmap_pkg::VEC_SIZE);
        impl = in_r(a, memmap_pkg::MON_BASE, memmap_pkg::MON_SIZE);
        n.sel.sel_mon = rd && impl;
        n.sel.sel_burn = in_r(a, memmap_pkg::BURN_BASE,
            memmap_pkg::BURN_SIZE);
        impl = impl || n.sel.sel_burn;
        n.sel.sel_burn = rd && n.sel.sel_burn;
        impl = impl || (n.sel != '0) || a <= 16'h0008 || a inside {16'hFE00,
            16'hFE01, 16'hFE03, [16'hFE07:16'hFE0C], 16'hFE0F, 16'hFF7E};
        n.ill = en_m && !impl;
        return n;
    endfunction

    task automatic acc(logic rd, logic [15:0] a, logic [7:0] wd, logic chk,
        logic [7:0] e);
        note_s n;
        n = expect_acc(rd, a);
        n.chk = chk;
        n.dat = e;
        if (n.ill) flag_m = 1'b1;
        if (!rd && a == 16'hFE0F) begin
            en_m = wd[0];
            if (wd[7]) flag_m = 1'b0;
        end
        notes.push_back(n);
        cpu_bus_model_i.put(rd, a, wd);
    endtask

    task automatic wr_reg(logic [15:0] a, logic [7:0] wd);
        acc(1'b0, a, wd, 1'b1, 8'h00);
    endtask

    task automatic rd_reg(logic [15:0] a, logic [7:0] e);
        acc(1'b1, a, 8'h00, 1'b1, e);
    endtask

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // --------------------------------------------------------------
    // output watcher and timeout
    // --------------------------------------------------------------
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) taken <= 1'b0;
        else taken <= req.rd | req.wr;
    end

    always @(negedge mclk) begin
        if (arst_n) begin
            cur = '0;
            if (taken && notes.size() == 0) begin
                failures++;
                $display("[FAIL] note queue exp entry got none");
            end else if (taken) cur = notes.pop_front();
            if (!taken || cur.chk) `CHK("rdata", cur.dat, rdata)
            `CHK("mem_sel", cur.sel, mem_sel)
            `CHK("illegal_reset", cur.ill, illegal_reset)
        end
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            tally_and_finish();
        end
    end

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        void'($urandom(32'hC3DB));
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        brk_in <= $urandom;
        rst_in <= $urandom;
        sup_in <= $urandom;
        irq_in <= $urandom;
        for (i = 4; i < 8; i++) rd_reg(16'(i), 8'h00);
        for (i = 0; i < 9; i++) begin
            d = $urandom;
            mem_m[i] = d & mask_t[i];
            wr_reg(16'(i), d);
        end
        for (i = 0; i < 9; i++) rd_reg(16'(i), mem_m[i]);
        rd_reg(16'hFE00, brk_in);
        rd_reg(16'hFE01, rst_in);
        rd_reg(16'hFE0C, sup_in);
        for (i = 9; i < 12; i++) rd_reg(16'hFE00 + 16'(i), irq_in);
        {h, l, c, d} = $urandom;
        wr_reg(16'hFE09, h);
        wr_reg(16'hFE0A, l);
        wr_reg(16'hFE03, d);
        wr_reg(16'hFE08, c);
        wr_reg(16'hFF7E, ~c);
        wr_reg(16'hFE0B, 8'h80);
        rd_reg(16'hFE03, d);
        rd_reg(16'hFE08, c);
        rd_reg(16'hFF7E, ~c);
        rd_reg(16'hFE09, h);
        rd_reg(16'hFE0A, l);
        cpu_bus_model_i.idle();
        repeat (3) @(posedge mclk);
        `CHK("break_addr", {h, l}, break_addr)
        `CHK("flash_ctrl", c, flash_ctrl)
        `CHK("port_dir_a", mem_m[4], port_dir_a)
        `CHK("port_dir_d", mem_m[7], port_dir_d)
        wr_reg(16'h0007, h);
        rd_reg(16'h0007, h & mask_t[7]);
        for (i = 0; i < 17; i++) begin
            wr_reg(edge_addr[i], $urandom);
            acc(1'b1, edge_addr[i], 8'h00, 1'b0, 8'h00);
        end
        // enable off, then back on with the sticky flag cleared
        wr_reg(16'hFE0F, 8'h00);
        wr_reg(16'h0009, 8'hA5);
        rd_reg(16'hFE0F, {flag_m, 6'h00, en_m});
        wr_reg(16'hFE0F, 8'h81);
        rd_reg(16'hFE0F, {flag_m, 6'h00, en_m});
        acc(1'b1, 16'hFFDB, 8'h00, 1'b0, 8'h00);
        rd_reg(16'hFE0F, {flag_m, 6'h00, en_m});
        cpu_bus_model_i.idle();
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        en_m = 1'b1;
        flag_m = 1'b0;
        for (i = 0; i < 9; i++)
            rd_reg(16'(i), (i > 3 && i < 8) ? 8'h00 : mem_m[i]);
        rd_reg(16'hFE08, 8'h00);
        rd_reg(16'hFE0F, {flag_m, 6'h00, en_m});
        cpu_bus_model_i.idle();
        repeat (3) @(posedge mclk);
        tally_and_finish();
    end
endmodule
